/* rtl/ttc_pkg.sv */
package ttc_pkg;
  // register indices, not byte addresses (byte address is four times the index)
  localparam logic [15:0] REG_SUPPORTED_MODES = 16'hb799;
  localparam logic [15:0] REG_RESET_DATE      = 16'hb7b7;
  localparam logic [15:0] REG_EDGE_TIMEOUT    = 16'hb7c5;
  localparam logic [15:0] REG_AUX_DIRECTION   = 16'hb7fc;
  localparam logic [15:0] REG_AUX_DATA        = 16'hb806;
  localparam logic [15:0] REG_RESET_TIME      = 16'hb7a0;
  localparam logic [15:0] REG_COMMAND         = 16'hb7a1;
  localparam logic [15:0] REG_STATUS          = 16'hb7a2;
  localparam logic [15:0] REG_STAMP_LO        = 16'hb7a3;
  localparam logic [15:0] REG_STAMP_HI        = 16'hb7a4;
  localparam logic [15:0] REG_TICK_LO         = 16'hb7a5;

  // command codes
  localparam logic [31:0] STAMP_OFF_CODE          = 32'h0000_0000;
  localparam int          COUNTER_CLEAR_BIT       = 0;
  localparam int          MANUAL_CLEAR_BIT        = 1;
  localparam int          CLEAR_ON_START_BIT      = 2;
  localparam int          FULL_WIDTH_BIT          = 8;
  localparam int          SPLIT_RISING_BIT        = 9;
  localparam int          SPLIT_FALLING_BIT       = 10;
  localparam int          AUX_CAPTURE_BIT         = 12;
  localparam logic [31:0] SUPPORTED_MODES_VALUE   = 32'h0000_1706;

  // aux direction
  localparam int          LOW_GROUP_OUT_BIT       = 0;
  localparam int          HIGH_GROUP_OUT_BIT      = 1;

  // timing
  localparam int          CLK_HZ                  = 40_000_000;
  localparam int          MS_PER_S                = 1000;
  localparam int          CYCLES_PER_MS           = CLK_HZ / MS_PER_S;
  localparam logic [31:0] TIMEOUT_RESET_MS        = 32'h0000_03e8;

  typedef enum logic [1:0] {
    TTC_IDLE     = 2'b00,
    TTC_WAIT_REF = 2'b01
  } ttc_state_type;
endpackage

/* rtl/ttc_timestamp.sv */
// Notes on behaviour
// - One command register holds the stamp mode and takes one-shot commands; zero is off.
// - The clear command zeroes the counter; in split modes only at the next reference edge.
// - A writable millisecond timeout bounds the wait for a reference edge.
// - In manual-clear mode only the explicit clear command zeroes the counter.
// - In clear-on-start mode every acquisition start zeroes the counter.
// - With full-width counting the whole counter advances on each sampling clock.
// - In split rising mode rising reference edges advance the upper part, samples the lower.
// - In split falling mode the upper part advances on falling reference edges instead.
// - With aux capture on, the aux inputs taken with the trigger fill each stamp's top byte.
// - With aux capture off, the top of each stamp is zero filled.
// - A read-only register reports the supported modes as a bitmap of the mode codes.
// - Time and date of the last counter reset are readable in two registers.
// - Aux direction is per nibble: bit 0 makes D3..D0 outputs, bit 1 makes D7..D4 outputs.
// - Reading aux data returns the live levels of all eight lines.
// - Writing aux data drives only output nibbles; input-nibble bits are dropped.
`timescale 1ns/100ps
`default_nettype none
module ttc_timestamp #(
  parameter int          CNT_W      = 56,
  parameter int          LO_W       = 32,
  parameter logic [31:0] CYC_PER_MS = 32'(ttc_pkg::CYCLES_PER_MS)
) (
  // clock, reset, enable
  input  wire logic        clk_i,
  input  wire logic        sys_rst_i,
  input  wire logic        clk_en_i,
  // register port
  input  wire logic [15:0] reg_addr_i,
  input  wire logic [31:0] reg_wdata_i,
  input  wire logic        reg_wr_i,
  input  wire logic        reg_rd_i,
  output logic      [31:0] reg_rdata_o,
  // acquisition events
  input  wire logic        acq_start_i,
  input  wire logic        trigger_i,
  input  wire logic        ref_clk_i,
  // stored stamp
  output logic      [63:0] stamp_o,
  output logic             stamp_valid_o,
  // aux lines
  input  wire logic [7:0]  aux_in_i,
  output logic      [7:0]  aux_out_o,
  output logic      [7:0]  aux_oe_o
);
  import ttc_pkg::*;

  typedef struct packed {
    ttc_state_type     state;
    logic [31:0]       mode;
    logic [31:0]       timeout_ms;
    logic [31:0]       reset_time;
    logic [31:0]       reset_date;
    logic [1:0]        dir;
    logic [7:0]        aux_out;
    logic [CNT_W-1:0]  cnt;
    logic              ref_prev;
    logic [31:0]       ms_div;
    logic [31:0]       ms_left;
    logic              timed_out;
    logic [63:0]       stamp;
    logic              stamp_valid;
    logic [31:0]       rdata;
  } ttc_regs_type;

  ttc_regs_type r_ff;
  ttc_regs_type nxt_r;

  function automatic logic [7:0] ttc_oe(input logic [1:0] d);
    ttc_oe = {{4{d[HIGH_GROUP_OUT_BIT]}}, {4{d[LOW_GROUP_OUT_BIT]}}};
  endfunction

  function automatic logic ttc_split(input logic [31:0] m);
    ttc_split = m[SPLIT_RISING_BIT] | m[SPLIT_FALLING_BIT];
  endfunction

  logic ref_edge;
  logic clr_now;
  logic wr_hit;
  logic [63:0] snap;

  always_comb begin
    nxt_r = r_ff;
    nxt_r.stamp_valid = 1'b0;
    nxt_r.ref_prev = ref_clk_i;
    ref_edge = (r_ff.mode[SPLIT_RISING_BIT] & ref_clk_i & ~r_ff.ref_prev)
             | (r_ff.mode[SPLIT_FALLING_BIT] & ~ref_clk_i & r_ff.ref_prev);
    clr_now = 1'b0;
    wr_hit = reg_wr_i;
    snap = '0;

    // counting
    if (r_ff.mode != STAMP_OFF_CODE) begin
      if (ttc_split(r_ff.mode)) begin
        nxt_r.cnt[LO_W-1:0] = r_ff.cnt[LO_W-1:0] + 1'b1;
        if (ref_edge) begin
          nxt_r.cnt[CNT_W-1:LO_W] = r_ff.cnt[CNT_W-1:LO_W] + 1'b1;
          nxt_r.cnt[LO_W-1:0] = '0;
        end
      end else if (r_ff.mode[FULL_WIDTH_BIT]) begin
        nxt_r.cnt = r_ff.cnt + 1'b1;
      end
    end

    // start reset
    if (acq_start_i && r_ff.mode[CLEAR_ON_START_BIT]) begin
      clr_now = 1'b1;
    end

    // wait for ref edge with ms timeout
    case (r_ff.state)
      TTC_IDLE: begin
        nxt_r.timed_out = r_ff.timed_out;
      end
      TTC_WAIT_REF: begin
        if (ref_edge) begin
          clr_now = 1'b1;
          nxt_r.state = TTC_IDLE;
        end else if (r_ff.ms_left == 32'h0) begin
          nxt_r.timed_out = 1'b1;
          nxt_r.state = TTC_IDLE;
        end else if (r_ff.ms_div == 32'h0) begin
          nxt_r.ms_div = CYC_PER_MS - 32'h1;
          nxt_r.ms_left = r_ff.ms_left - 32'h1;
        end else begin
          nxt_r.ms_div = r_ff.ms_div - 32'h1;
        end
      end
      default: nxt_r.state = TTC_IDLE;
    endcase

    if (clr_now) begin
      nxt_r.cnt = '0;
      nxt_r.reset_time = r_ff.reset_time + 32'h1;
    end

    // trigger capture
    if (trigger_i && r_ff.mode != STAMP_OFF_CODE) begin
      snap[CNT_W-1:0] = r_ff.cnt;
      if (r_ff.mode[AUX_CAPTURE_BIT]) begin
        snap[63:56] = aux_in_i;
      end else begin
        snap[63:CNT_W] = '0;
      end
      nxt_r.stamp = snap;
      nxt_r.stamp_valid = 1'b1;
    end

    // register writes
    if (wr_hit) begin
      case (reg_addr_i)
        REG_COMMAND: begin
          nxt_r.mode = reg_wdata_i & ~32'h1;
          if (reg_wdata_i[COUNTER_CLEAR_BIT]) begin
            nxt_r.mode = r_ff.mode; // a bare clear keeps the mode
            if (ttc_split(r_ff.mode)) begin
              nxt_r.state = TTC_WAIT_REF;
              nxt_r.ms_div = CYC_PER_MS - 32'h1;
              nxt_r.ms_left = r_ff.timeout_ms;
              nxt_r.timed_out = 1'b0;
            end else begin
              nxt_r.cnt = '0;
              nxt_r.reset_time = r_ff.reset_time + 32'h1;
            end
          end
        end
        REG_EDGE_TIMEOUT: nxt_r.timeout_ms = reg_wdata_i;
        REG_RESET_TIME:   nxt_r.reset_time = reg_wdata_i;
        REG_RESET_DATE:   nxt_r.reset_date = reg_wdata_i;
        REG_AUX_DIRECTION: nxt_r.dir = reg_wdata_i[1:0];
        REG_AUX_DATA: begin
          nxt_r.aux_out = (reg_wdata_i[7:0] & ttc_oe(r_ff.dir))
                        | (r_ff.aux_out & ~ttc_oe(r_ff.dir));
        end
        default: nxt_r.rdata = r_ff.rdata;
      endcase
    end

    // register reads, data stands one cycle later only
    nxt_r.rdata = 32'h0;
    if (reg_rd_i) begin
      case (reg_addr_i)
        REG_SUPPORTED_MODES: nxt_r.rdata = SUPPORTED_MODES_VALUE;
        REG_COMMAND:         nxt_r.rdata = r_ff.mode;
        REG_EDGE_TIMEOUT:    nxt_r.rdata = r_ff.timeout_ms;
        REG_RESET_TIME:      nxt_r.rdata = r_ff.reset_time;
        REG_RESET_DATE:      nxt_r.rdata = r_ff.reset_date;
        REG_AUX_DIRECTION:   nxt_r.rdata = {30'h0, r_ff.dir};
        REG_AUX_DATA:        nxt_r.rdata = {24'h0, aux_in_i};
        REG_STATUS:          nxt_r.rdata = {30'h0, r_ff.timed_out,
                                            r_ff.state == TTC_WAIT_REF};
        REG_STAMP_LO:        nxt_r.rdata = r_ff.stamp[31:0];
        REG_STAMP_HI:        nxt_r.rdata = r_ff.stamp[63:32];
        REG_TICK_LO:         nxt_r.rdata = r_ff.cnt[31:0];
        default:             nxt_r.rdata = 32'h0;
      endcase
    end
  end

  always_ff @(posedge clk_i) begin
    if (sys_rst_i) begin
      r_ff <= '0;
      r_ff.state <= TTC_IDLE;
      r_ff.timeout_ms <= TIMEOUT_RESET_MS;
    end else if (clk_en_i) begin
      r_ff <= nxt_r;
    end
  end

  assign reg_rdata_o   = r_ff.rdata;
  assign stamp_o       = r_ff.stamp;
  assign stamp_valid_o = r_ff.stamp_valid;
  assign aux_out_o     = r_ff.aux_out;
  assign aux_oe_o      = ttc_oe(r_ff.dir);
endmodule
`default_nettype wire

/* dv/ttc_ext_src.sv */
`timescale 1ns/100ps
`default_nettype none
module ttc_ext_src (
  // clock and run control
  input  wire logic       clk_i,
  input  wire logic       run_i,
  // aux line levels
  input  wire logic [7:0] pat_i,
  input  wire logic [7:0] out_i,
  input  wire logic [7:0] oe_i,
  // far side outputs
  output var  logic       ref_o,
  output wire logic [7:0] pin_o
);
  int n = 0;
  initial ref_o = 1'b0;
  // period of six sampling cycles; frozen while run is low so a clear can time out
  always @(posedge clk_i)
    if (run_i) begin
      n <= n + 1;
      if (n % 3 == 2)
        ref_o <= !ref_o;
    end
  // input nibbles are driven from here, output nibbles come back from the block
  assign pin_o = (out_i & oe_i) | (pat_i & ~oe_i);
endmodule
`default_nettype wire

/* dv/ttc_timestamp_props.sv */
`timescale 1ns/100ps
`default_nettype none
module ttc_timestamp_props (
  input wire logic        clk_i,
  input wire logic        sys_rst_i,
  input wire logic        clk_en_i,
  input wire logic [15:0] reg_addr_i,
  input wire logic [31:0] reg_wdata_i,
  input wire logic        reg_wr_i,
  input wire logic        reg_rd_i,
  input wire logic [31:0] reg_rdata_o,
  input wire logic        acq_start_i,
  input wire logic        trigger_i,
  input wire logic [63:0] stamp_o,
  input wire logic        stamp_valid_o,
  input wire logic [7:0]  aux_in_i,
  input wire logic [7:0]  aux_out_o,
  input wire logic [7:0]  aux_oe_o
);
  import ttc_pkg::*;
  logic [31:0] mode_ff;
  logic [55:0] cnt;
  logic [15:0] adr;
  logic [7:0]  oe_x, wlo;
  logic        rd, wr, trg, on;
  assign cnt = stamp_o[55:0];
  assign adr = reg_addr_i;
  assign wlo = reg_wdata_i[7:0];
  assign rd = clk_en_i && reg_rd_i;
  assign wr = clk_en_i && reg_wr_i;
  assign on = mode_ff != STAMP_OFF_CODE;
  assign trg = clk_en_i && trigger_i && on;
  assign oe_x = {{4{reg_wdata_i[1]}}, {4{reg_wdata_i[0]}}};
  // a write carrying the clear bit leaves the stored mode alone
  always_ff @(posedge clk_i)
    if (sys_rst_i)
      mode_ff <= STAMP_OFF_CODE;
    else if (wr && adr == REG_COMMAND && !reg_wdata_i[0])
      mode_ff <= reg_wdata_i;
  default clocking @(posedge clk_i); endclocking
  default disable iff (sys_rst_i);
  sequence s_two; trg && mode_ff[8] && !wr && !acq_start_i ##1 trg; endsequence
  sequence s_clr; wr && adr == REG_COMMAND && reg_wdata_i[0] && mode_ff[8] ##1 trg; endsequence
  property p_md;
    rd && adr == REG_SUPPORTED_MODES |=> reg_rdata_o == SUPPORTED_MODES_VALUE; endproperty
  a_md: assert property (p_md) else $error("modes");
  property p_dir; wr && adr == REG_AUX_DIRECTION |=> aux_oe_o == $past(oe_x); endproperty
  a_dir: assert property (p_dir) else $error("direction");
  property p_pin; rd && adr == REG_AUX_DATA |=> reg_rdata_o[7:0] == $past(aux_in_i); endproperty
  a_pin: assert property (p_pin) else $error("pins");
  property p_out;
    wr && adr == REG_AUX_DATA |=> (aux_out_o & aux_oe_o) == ($past(wlo) & aux_oe_o); endproperty
  a_out: assert property (p_out) else $error("drive");
  property p_stb; trg |=> stamp_valid_o; endproperty
  a_stb: assert property (p_stb) else $error("stamp");
  property p_off; clk_en_i && !on |=> !stamp_valid_o; endproperty
  a_off: assert property (p_off) else $error("off");
  property p_cap; trg && mode_ff[12] |=> stamp_o[63:56] == $past(aux_in_i); endproperty
  a_cap: assert property (p_cap) else $error("capture");
  property p_cnt; s_two |=> cnt == $past(cnt) + 56'h1; endproperty
  a_cnt: assert property (p_cnt) else $error("count");
  property p_clr; s_clr |=> cnt <= 56'h1; endproperty
  a_clr: assert property (p_clr) else $error("clear");
endmodule
bind ttc_timestamp ttc_timestamp_props u_ttc_timestamp_props (
  .clk_i         (clk_i),
  .sys_rst_i     (sys_rst_i),
  .clk_en_i      (clk_en_i),
  .reg_addr_i    (reg_addr_i),
  .reg_wdata_i   (reg_wdata_i),
  .reg_wr_i      (reg_wr_i),
  .reg_rd_i      (reg_rd_i),
  .reg_rdata_o   (reg_rdata_o),
  .acq_start_i   (acq_start_i),
  .trigger_i     (trigger_i),
  .stamp_o       (stamp_o),
  .stamp_valid_o (stamp_valid_o),
  .aux_in_i      (aux_in_i),
  .aux_out_o     (aux_out_o),
  .aux_oe_o      (aux_oe_o)
);
`default_nettype wire

/* dv/ttc_timestamp_tb.sv */
`timescale 1ns/100ps
`default_nettype none
module ttc_timestamp_tb;
  import ttc_pkg::*;
  logic        clk_i = 0, sys_rst_i = 1, reg_wr_i = 0, reg_rd_i = 0, run = 0;
  logic        clk_en_i = 1;
  logic        trigger_i = 0, acq_start_i = 0, stamp_valid_o, ref_clk_i;
  logic [15:0] reg_addr_i = '0;
  logic [31:0] reg_wdata_i = '0, reg_rdata_o, d, v;
  logic [63:0] stamp_o;
  logic [55:0] sq[$];
  logic [7:0]  aux_in_i, aux_out_o, aux_oe_o, m, pat = '0;
  int          fail_count = 0, compares = 0;
  always #12.5 clk_i = !clk_i;
  ttc_timestamp #(.CYC_PER_MS(32'h4)) u_ttc_timestamp (
    .clk_i         (clk_i),
    .sys_rst_i     (sys_rst_i),
    .clk_en_i      (clk_en_i),
    .reg_addr_i    (reg_addr_i),
    .reg_wdata_i   (reg_wdata_i),
    .reg_wr_i      (reg_wr_i),
    .reg_rd_i      (reg_rd_i),
    .reg_rdata_o   (reg_rdata_o),
    .acq_start_i   (acq_start_i),
    .trigger_i     (trigger_i),
    .ref_clk_i     (ref_clk_i),
    .stamp_o       (stamp_o),
    .stamp_valid_o (stamp_valid_o),
    .aux_in_i      (aux_in_i),
    .aux_out_o     (aux_out_o),
    .aux_oe_o      (aux_oe_o)
  );
  ttc_ext_src u_ttc_ext_src (.clk_i(clk_i), .run_i(run), .pat_i(pat), .out_i(aux_out_o),
    .oe_i(aux_oe_o), .ref_o(ref_clk_i), .pin_o(aux_in_i));
  task chk(input logic [63:0] got, input logic [63:0] exp);
    compares++;
    if (got !== exp) begin
      fail_count++;
      $display("BAD %0t got %h want %h", $time, got, exp);
    end
  endtask
  task wrt(input logic [15:0] a, input logic [31:0] x);
    @(posedge clk_i);
    reg_addr_i <= a;
    reg_wdata_i <= x;
    reg_wr_i <= 1;
    @(posedge clk_i);
    reg_wr_i <= 0;
  endtask
  task rdr(input logic [15:0] a);
    @(posedge clk_i);
    reg_addr_i <= a;
    reg_rd_i <= 1;
    @(posedge clk_i);
    reg_rd_i <= 0;
    #1 d = reg_rdata_o;
  endtask
  // start pulse one cycle ahead of the trigger, so a start clear cannot race it
  task fire(input logic s, input logic on, input logic [7:0] top);
    @(posedge clk_i);
    acq_start_i <= s;
    @(posedge clk_i);
    acq_start_i <= 0;
    trigger_i <= 1;
    @(posedge clk_i);
    trigger_i <= 0;
    #1 chk(stamp_valid_o, on);
    sq.push_back(stamp_o[55:0]);
    if (on)
      chk(stamp_o[63:56], top);
  endtask
  task summarize;
    if (fail_count == 0 && compares > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask
  initial begin
    repeat (4000) @(posedge clk_i);
    fail_count++;
    summarize();
  end
  initial begin
    v = $urandom(1);
    repeat (4) @(posedge clk_i);
    sys_rst_i <= 0;
    rdr(REG_SUPPORTED_MODES);
    chk(d, SUPPORTED_MODES_VALUE);
    rdr(16'h0000);
    chk(d, 0);
    fire(0, 0, 0);
    for (int i = 0; i < 4; i++) begin
      pat <= 8'($urandom);
      wrt(REG_AUX_DIRECTION, 32'(i));
      v = $urandom;
      wrt(REG_AUX_DATA, v);
      rdr(REG_AUX_DATA);
      m = {{4{i[1]}}, {4{i[0]}}};
      chk(aux_oe_o, m);
      chk(aux_out_o & m, v[7:0] & m);
      chk(d[7:0], (v[7:0] & m) | (pat & ~m));
    end
    wrt(REG_AUX_DIRECTION, 32'h0);
    wrt(REG_COMMAND, 32'h1102);
    rdr(REG_RESET_TIME);
    v = d;
    wrt(REG_COMMAND, 32'h1);
    for (int i = 0; i < 40; i++) begin
      // the first two are forced so the clear and back-to-back checks always see stamps
      trigger_i <= (i < 2) || 1'($urandom);
      @(posedge clk_i);
    end
    trigger_i <= 0;
    rdr(REG_RESET_TIME);
    chk(d, v + 32'h1);
    fire(0, 1, pat);
    fire(1, 1, pat);
    chk(sq[$] - sq[$-1], 3);
    // a low enable for five edges must hold the counter still
    @(posedge clk_i);
    clk_en_i <= 0;
    repeat (5) @(posedge clk_i);
    clk_en_i <= 1;
    fire(0, 1, pat);
    chk(sq[$] - sq[$-1], 4);
    wrt(REG_COMMAND, 32'h104);
    fire(1, 1, 0);
    chk(sq[$] <= 1, 1);
    run <= 1;
    for (int i = 1; i < 3; i++) begin
      wrt(REG_COMMAND, (32'h100 << i) | 32'h2);
      wrt(REG_COMMAND, 32'h1);
      repeat (40) @(posedge clk_i);
      fire(0, 1, 0);
      chk(sq[$][55:32] != 0, 1);
      chk(sq[$][31:0] < 8, 1);
    end
    run <= 0;
    wrt(REG_EDGE_TIMEOUT, 32'h2);
    wrt(REG_COMMAND, 32'h1);
    rdr(REG_STATUS);
    chk(d[1:0], 2'b01);
    repeat (12) @(posedge clk_i);
    rdr(REG_STATUS);
    chk(d[1:0], 2'b10);
    summarize();
  end
endmodule
`default_nettype wire
